// *** hdl/dcs_codec.sv ***
// Coded squelch word encoder and received-word decoder
`include "dcs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module dcs_codec
   import dcs_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset,
   // Settings and front-panel events
   input  wire dcs_cfg_t         cfg,
   input  wire logic             encoder_view,
   input  wire logic             onoff_press,
   input  wire logic             gen_freq_write,
   // Encoder outputs
   output var  logic             gen_enabled_q,
   output var  logic             mod_b_bit_q,
   output var  logic             mod_b_active_q,
   output var  logic             audio_b_bit_q,
   output var  logic             audio_b_active_q,
   // Decoder input and result
   input  wire logic             rx_bit,
   output var  logic             sync_flag_q,
   output var  dcs_dec_result_t  result_q
);

   localparam logic [`DCS_NUM_CODES*`DCS_CODE_BITS-1:0] CODE_TABLE = `DCS_CODE_TABLE;

   // Check bits: remainder of data times x^11 by the cyclic generator
   function automatic logic [`DCS_PAR_BITS-1:0] dcs_parity(input logic [`DCS_DATA_BITS-1:0] d);
      logic [`DCS_WORD_BITS-1:0] r;
      r = {d, {`DCS_PAR_BITS{1'b0}}};
      for (int i = `DCS_WORD_BITS-1; i >= `DCS_PAR_BITS; i--) begin
         if (r[i]) begin
            r = r ^ (`DCS_GOLAY_POLY << (i - `DCS_PAR_BITS));
         end
      end
      return r[`DCS_PAR_BITS-1:0];
   endfunction : dcs_parity

   function automatic logic [`DCS_WORD_BITS-1:0] dcs_word(input logic [`DCS_CODE_BITS-1:0] c);
      logic [`DCS_DATA_BITS-1:0] d;
      d = {`DCS_SYNC_PATTERN, c};
      return {dcs_parity(d), d};
   endfunction : dcs_word

   // Rate to divider count; zero rate falls back to the usual rate
   function automatic logic [31:0] dcs_div(input logic [15:0] rate);
      logic [15:0] r;
      r = (rate == 16'h0000) ? `DCS_RATE_DEF : rate;
      return `DCS_CLK_HZ / {16'h0000, r};
   endfunction : dcs_div

   // ---------------- Bit-rate dividers ----------------
   logic [15:0] dec_rate;
   logic [31:0] enc_div_d, enc_div_q, dec_div_d, dec_div_q;
   logic [31:0] enc_cnt_d, enc_cnt_q, dec_cnt_d, dec_cnt_q;
   logic        enc_strobe, dec_strobe;
   dcs_enc_state_t enc_state_d, enc_state_q;

   always_comb begin
      dec_rate = cfg.dec_rate_hz;
      if (dec_rate < `DCS_DEC_RATE_MIN) begin
         dec_rate = `DCS_DEC_RATE_MIN;
      end else if (dec_rate > `DCS_DEC_RATE_MAX) begin
         dec_rate = `DCS_DEC_RATE_MAX;
      end
      // Divider is registered so the long division is off the counter path
      enc_div_d  = dcs_div(cfg.enc_rate_hz);
      dec_div_d  = dcs_div(dec_rate);
      enc_strobe = (enc_state_q == DCS_ENC_RUN) && (enc_cnt_q >= enc_div_q - 32'd1);
      dec_strobe = (dec_cnt_q >= dec_div_q - 32'd1);
      enc_cnt_d  = (enc_state_q != DCS_ENC_RUN || enc_strobe) ? 32'd0 : enc_cnt_q + 32'd1;
      dec_cnt_d  = dec_strobe ? 32'd0 : dec_cnt_q + 32'd1;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         enc_div_q <= 32'hffffffff;
         dec_div_q <= 32'hffffffff;
         enc_cnt_q <= 32'd0;
         dec_cnt_q <= 32'd0;
      end else begin
         enc_div_q <= enc_div_d;
         dec_div_q <= dec_div_d;
         enc_cnt_q <= enc_cnt_d;
         dec_cnt_q <= dec_cnt_d;
      end
   end

   // ---------------- Encoder ----------------
   logic                      en_d, en_q;
   logic [`DCS_WORD_BITS-1:0] word_d, word_q;
   logic [4:0]                idx_d, idx_q;
   logic                      bit_d, bit_q;
   logic                      level;

   always_comb begin
      en_d        = en_q;
      enc_state_d = enc_state_q;
      word_d      = word_q;
      idx_d       = idx_q;
      bit_d       = bit_q;
      // Frequency entry on the carrying generator wins over a press
      if (gen_freq_write) begin
         en_d = 1'b0;
      end else if (onoff_press && encoder_view) begin
         en_d = ~en_q;
      end
      // No mode input on purpose: test-mode changes leave generation alone
      case (enc_state_q)
         DCS_ENC_IDLE: begin
            idx_d = 5'd0;
            if (en_q) begin
               enc_state_d = DCS_ENC_RUN;
               word_d      = dcs_word(cfg.code);
               bit_d       = word_d[0];
               idx_d       = 5'd1;
            end
         end
         DCS_ENC_RUN: begin
            if (!en_q) begin
               enc_state_d = DCS_ENC_IDLE;
            end else if (enc_strobe) begin
               // Code changes take effect at the next word boundary
               if (idx_q > `DCS_LAST_BIT) begin
                  word_d = dcs_word(cfg.code);
                  bit_d  = word_d[0];
                  idx_d  = 5'd1;
               end else begin
                  bit_d = word_q[idx_q];
                  idx_d = idx_q + 5'd1;
               end
            end
         end
         default: enc_state_d = DCS_ENC_IDLE;
      endcase
      level = bit_d ^ cfg.invert;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         en_q             <= 1'b0;
         enc_state_q      <= DCS_ENC_IDLE;
         word_q           <= '0;
         idx_q            <= 5'd0;
         bit_q            <= 1'b0;
         gen_enabled_q    <= 1'b0;
         mod_b_bit_q      <= 1'b0;
         mod_b_active_q   <= 1'b0;
         audio_b_bit_q    <= 1'b0;
         audio_b_active_q <= 1'b0;
      end else begin
         en_q             <= en_d;
         enc_state_q      <= enc_state_d;
         word_q           <= word_d;
         idx_q            <= idx_d;
         bit_q            <= bit_d;
         gen_enabled_q    <= en_d;
         mod_b_active_q   <= (enc_state_d == DCS_ENC_RUN) && !cfg.route_audio;
         audio_b_active_q <= (enc_state_d == DCS_ENC_RUN) && cfg.route_audio;
         mod_b_bit_q      <= (enc_state_d == DCS_ENC_RUN) && !cfg.route_audio && level;
         audio_b_bit_q    <= (enc_state_d == DCS_ENC_RUN) && cfg.route_audio && level;
      end
   end

   // ---------------- Decoder ----------------
   logic                      rx_meta_q, rx_sync_q;
   logic [`DCS_WORD_BITS-1:0] shift_d, shift_q;
   logic                      hit;
   logic                      permitted;
   dcs_dec_result_t           result_d;

   always_comb begin
      shift_d = shift_q;
      if (dec_strobe) begin
         // Oldest bit settles at index 0, i.e. word bit 1
         shift_d = {rx_sync_q, shift_q[`DCS_WORD_BITS-1:1]};
      end
      hit       = dec_strobe && (shift_d[`DCS_SYNC_HI:`DCS_SYNC_LO] == `DCS_SYNC_PATTERN);
      permitted = 1'b0;
      for (int k = 0; k < `DCS_NUM_CODES; k++) begin
         if (CODE_TABLE[k*`DCS_CODE_BITS +: `DCS_CODE_BITS] == shift_d[`DCS_CODE_BITS-1:0]) begin
            permitted = 1'b1;
         end
      end
      result_d       = result_q;
      result_d.valid = hit;
      if (hit) begin
         result_d.sample    = shift_d;
         result_d.code      = shift_d[`DCS_CODE_BITS-1:0];
         result_d.permitted = permitted;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rx_meta_q   <= 1'b0;
         rx_sync_q   <= 1'b0;
         shift_q     <= '0;
         sync_flag_q <= 1'b0;
         result_q    <= '0;
      end else begin
         rx_meta_q   <= rx_bit;
         rx_sync_q   <= rx_meta_q;
         shift_q     <= shift_d;
         sync_flag_q <= hit;
         result_q    <= result_d;
      end
   end

endmodule : dcs_codec

`default_nettype wire

// *** hdl/dcs_cfg.svh ***
// Constants of the coded squelch encoder and decoder
//
// Operation
// - The encoder sends the selected code as one 23-bit word, repeated back to back while generation is enabled.
// - Each word holds 14 bits of check and timing content and 9 bits of address code.
// - The serial output holds each bit for a full bit period with no return to zero and feeds modulation generator b or audio generator b.
// - A polarity setting selects normal (one high, zero low) or inverted output levels.
// - The encoder bit rate is programmable in hertz, normally 134 bits per second.
// - The decoder bit rate is selectable from 100 to 200 bits per second.
// - The code setting takes any octal value 0 to 777 and forms the 9-bit address field.
// - The decoder shifts received bits through a compare register and flags every 0 0 1 pattern.
// - On each flag the decoder captures a 23-bit sample with the pattern in bit positions 12, 11 and 10.
// - The decoder takes bits 1 to 9 of the sample as the code and reports the whole sample.
// - The decoder compares the code against a table of 104 permitted codes and flags a match.
// - One on/off press inverts the generation state while the encoder view is active.
// - Generation keeps running across changes of the operating test mode.
// - Generation drives modulation generator b when routed to RF, audio generator b when routed to audio.
// - A new or adjusted frequency on the carrying generator stops generation; restart only from the encoder view.
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

`define DCS_CLK_HZ        32'd50000000
`define DCS_WORD_BITS     23
`define DCS_CODE_BITS     9
`define DCS_DATA_BITS     12
`define DCS_PAR_BITS      11
`define DCS_SYNC_PATTERN  3'b001
`define DCS_SYNC_HI       11
`define DCS_SYNC_LO       9
`define DCS_GOLAY_POLY    23'h000ae3
`define DCS_RATE_DEF      16'd134
`define DCS_DEC_RATE_MIN  16'd100
`define DCS_DEC_RATE_MAX  16'd200
`define DCS_LAST_BIT      5'd22
`define DCS_NUM_CODES     104
`define DCS_CODE_TABLE { \
   9'o023, 9'o025, 9'o026, 9'o031, 9'o032, 9'o036, 9'o043, 9'o047, 9'o051, 9'o053, \
   9'o054, 9'o065, 9'o071, 9'o072, 9'o073, 9'o074, 9'o114, 9'o115, 9'o116, 9'o122, \
   9'o125, 9'o131, 9'o132, 9'o134, 9'o143, 9'o145, 9'o152, 9'o155, 9'o156, 9'o162, \
   9'o165, 9'o172, 9'o174, 9'o205, 9'o212, 9'o223, 9'o225, 9'o226, 9'o243, 9'o244, \
   9'o245, 9'o246, 9'o251, 9'o252, 9'o255, 9'o261, 9'o263, 9'o265, 9'o266, 9'o271, \
   9'o274, 9'o306, 9'o311, 9'o315, 9'o325, 9'o331, 9'o332, 9'o343, 9'o346, 9'o351, \
   9'o356, 9'o364, 9'o365, 9'o371, 9'o411, 9'o412, 9'o413, 9'o423, 9'o431, 9'o432, \
   9'o445, 9'o446, 9'o452, 9'o454, 9'o455, 9'o462, 9'o464, 9'o465, 9'o466, 9'o503, \
   9'o506, 9'o516, 9'o523, 9'o526, 9'o532, 9'o546, 9'o565, 9'o606, 9'o612, 9'o624, \
   9'o627, 9'o631, 9'o632, 9'o654, 9'o662, 9'o664, 9'o703, 9'o712, 9'o723, 9'o731, \
   9'o732, 9'o734, 9'o743, 9'o754}

`endif

// *** hdl/dcs_pkg.sv ***
// Types shared by the coded squelch encoder and decoder
`include "dcs_cfg.svh"

package dcs_pkg;

   typedef enum logic {DCS_ENC_IDLE, DCS_ENC_RUN} dcs_enc_state_t;

   typedef struct packed {
      logic [`DCS_CODE_BITS-1:0] code;
      logic                      invert;
      logic                      route_audio;
      logic [15:0]               enc_rate_hz;
      logic [15:0]               dec_rate_hz;
   } dcs_cfg_t;

   typedef struct packed {
      logic                      valid;
      logic                      permitted;
      logic [`DCS_CODE_BITS-1:0] code;
      logic [`DCS_WORD_BITS-1:0] sample;
   } dcs_dec_result_t;

endpackage : dcs_pkg

// *** testbench/dcs_codec_assertions.sv ***
// Port checks for the coded squelch codec
`timescale 1ns/100ps
`default_nettype none
module dcs_codec_assertions
   import dcs_pkg::*;
(
   // Clock and reset
   input wire logic            clk_sys,
   input wire logic            reset,
   // Controls
   input wire dcs_cfg_t        cfg,
   input wire logic            encoder_view,
   input wire logic            onoff_press,
   input wire logic            gen_freq_write,
   // Outputs
   input wire logic            gen_enabled_q,
   input wire logic            mod_b_bit_q,
   input wire logic            mod_b_active_q,
   input wire logic            audio_b_bit_q,
   input wire logic            audio_b_active_q,
   input wire logic            sync_flag_q,
   input wire dcs_dec_result_t result_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   chk_stop_wins: assert property (gen_freq_write |=> !gen_enabled_q)
      else $error("enable kept after frequency write");
   chk_press_toggle: assert property (onoff_press && encoder_view && !gen_freq_write |=>
      gen_enabled_q != $past(gen_enabled_q)) else $error("press did not toggle");
   chk_view_gate: assert property (onoff_press && !encoder_view && !gen_freq_write |=>
      $stable(gen_enabled_q)) else $error("press outside encoder view acted");
   chk_route_rf: assert property ($rose(gen_enabled_q) && !cfg.route_audio |=>
      mod_b_active_q && !audio_b_active_q) else $error("rf route wrong");
   chk_route_af: assert property ($rose(gen_enabled_q) && cfg.route_audio |=>
      audio_b_active_q && !mod_b_active_q) else $error("audio route wrong");
   chk_stop_quiet: assert property ($fell(gen_enabled_q) |-> ##[0:2]
      !mod_b_active_q && !audio_b_active_q) else $error("outputs still active");
   chk_idle_low: assert property ((mod_b_active_q || !mod_b_bit_q)
      && (audio_b_active_q || !audio_b_bit_q)) else $error("idle line not low");
   chk_bit_hold: assert property (mod_b_active_q && $changed(mod_b_bit_q) |=>
      ($stable(mod_b_bit_q) || !mod_b_active_q)[*8]) else $error("bit too short");
   chk_sync_pair: assert property (sync_flag_q == result_q.valid)
      else $error("flag and valid differ");
   chk_sync_align: assert property (result_q.valid |-> result_q.sample[11:9] == 3'b001
      && result_q.code == result_q.sample[8:0]) else $error("sample misaligned");
endmodule : dcs_codec_assertions
`default_nettype wire

// *** testbench/dcs_radio_model.sv ***
// Radio under test: echoes the heard code back on its reverse channel
`timescale 1ns/100ps
`default_nettype none
module dcs_radio_model (
   // Clock
   input  wire logic clk_sys,
   // Heard code
   input  wire logic mod_bit,
   input  wire logic mod_on,
   input  wire logic af_bit,
   input  wire logic af_on,
   // Reverse channel
   output var  logic rx_line
);
   logic idle_q = 1'b0;
   // Silent channel must not read as a steady level
   // Plain always: the start value comes from the declaration, the model has no reset
   always @(posedge clk_sys) begin
      idle_q <= ~idle_q;
   end
   assign rx_line = mod_on ? mod_bit : (af_on ? af_bit : idle_q);
endmodule : dcs_radio_model
`default_nettype wire

// *** testbench/dcs_codec_bench.sv ***
// Self-checking bench for the coded squelch codec
`timescale 1ns/100ps
`default_nettype none
module dcs_codec_bench;
   import dcs_pkg::*;
   logic            clk_sys, reset, encoder_view, onoff_press, gen_freq_write, rx_bit;
   logic            gen_enabled_q, mod_b_bit_q, mod_b_active_q, audio_b_bit_q, audio_b_active_q;
   logic            sync_flag_q;
   dcs_cfg_t        cfg;
   dcs_dec_result_t result_q;
   int              bad_count = 0;
   int              n_compared = 0;
   dcs_codec dcs_codec_inst (.clk_sys(clk_sys), .reset(reset), .cfg(cfg), .encoder_view(encoder_view),
      .onoff_press(onoff_press), .gen_freq_write(gen_freq_write), .gen_enabled_q(gen_enabled_q),
      .mod_b_bit_q(mod_b_bit_q), .mod_b_active_q(mod_b_active_q), .audio_b_bit_q(audio_b_bit_q),
      .audio_b_active_q(audio_b_active_q), .rx_bit(rx_bit), .sync_flag_q(sync_flag_q), .result_q(result_q));
   dcs_radio_model dcs_radio_model_inst (.clk_sys(clk_sys), .mod_bit(mod_b_bit_q), .mod_on(mod_b_active_q),
      .af_bit(audio_b_bit_q), .af_on(audio_b_active_q), .rx_line(rx_bit));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic stop_test;
      if (bad_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [22:0] seen, input logic [22:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Word built from the code with its cyclic check bits
   function automatic logic [22:0] word_of(input logic [8:0] code);
      logic [22:0] r;
      r = {3'b001, code, 11'h000};
      for (int i = 22; i >= 11; i--) begin
         if (r[i]) r = r ^ (23'h000ae3 << (i - 11));
      end
      return {r[10:0], 3'b001, code};
   endfunction : word_of
   task automatic pulse(input logic view, input logic stop);
      @(negedge clk_sys);
      encoder_view = view;
      onoff_press = 1'b1;
      gen_freq_write = stop;
      @(negedge clk_sys);
      onoff_press = 1'b0;
      gen_freq_write = 1'b0;
   endtask : pulse
   // Samples mid-bit; 65535 Hz gives 762 clocks a bit
   task automatic grab(input logic af, input int words, input logic [22:0] exp);
      logic [22:0] w;
      for (int i = 0; i < 8 && !(af ? audio_b_active_q : mod_b_active_q); i++) @(negedge clk_sys);
      check("route", 23'({audio_b_active_q, mod_b_active_q}), af ? 23'h2 : 23'h1);
      repeat (381) @(negedge clk_sys);
      for (int k = 0; k < words * 23; k++) begin
         w[k % 23] = af ? audio_b_bit_q : mod_b_bit_q;
         if (k % 23 == 22) check("word", w, exp);
         repeat (762) @(negedge clk_sys);
      end
   endtask : grab
   initial begin
      reset = 1'b1;
      cfg = '0;
      encoder_view = 1'b0;
      onoff_press = 1'b0;
      gen_freq_write = 1'b0;
      cfg.enc_rate_hz = 16'hffff;
      // Above the decoder range; the clamp must hold it at the fast end
      cfg.dec_rate_hz = 16'hffff;
      cfg.code = 9'o023;
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      check("idle", 23'({sync_flag_q, gen_enabled_q, mod_b_active_q, audio_b_active_q}), 23'h0);
      pulse(1'b0, 1'b0);
      check("gated", 23'(gen_enabled_q), 23'h0);
      pulse(1'b1, 1'b0);
      grab(1'b0, 2, word_of(9'o023));
      pulse(1'b1, 1'b0);
      check("off", 23'(gen_enabled_q), 23'h0);
      cfg.route_audio = 1'b1;
      cfg.invert = 1'b1;
      cfg.code = 9'o754;
      pulse(1'b1, 1'b0);
      grab(1'b1, 1, ~word_of(9'o754));
      pulse(1'b0, 1'b1);
      repeat (3) @(negedge clk_sys);
      check("stop", 23'({gen_enabled_q, audio_b_active_q, audio_b_bit_q}), 23'h0);
      pulse(1'b1, 1'b1);
      check("stop wins", 23'(gen_enabled_q), 23'h0);
      pulse(1'b0, 1'b0);
      check("no restart", 23'(gen_enabled_q), 23'h0);
      pulse(1'b1, 1'b0);
      check("restart", 23'(gen_enabled_q), 23'h1);
      // Clamped decoder strobes once per 250000 clocks, so nothing is decoded yet
      check("dec code", 23'({sync_flag_q, result_q.valid, result_q.permitted, result_q.code}), 23'h0);
      check("dec sample", result_q.sample, 23'h0);
      repeat (2) @(negedge clk_sys);
      check("running", 23'({gen_enabled_q, audio_b_active_q}), 23'h3);
      reset = 1'b1;
      @(negedge clk_sys);
      check("reset", 23'({gen_enabled_q, mod_b_active_q, audio_b_active_q, mod_b_bit_q, audio_b_bit_q}), 23'h0);
      reset = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("after reset", 23'({gen_enabled_q, mod_b_active_q, audio_b_active_q, audio_b_bit_q}), 23'h0);
      stop_test();
   end
   initial begin
      repeat (90000) @(posedge clk_sys);
      bad_count++;
      stop_test();
   end
endmodule : dcs_codec_bench
bind dcs_codec dcs_codec_assertions dcs_codec_assertions_inst (.clk_sys(clk_sys), .reset(reset), .cfg(cfg),
   .encoder_view(encoder_view), .onoff_press(onoff_press), .gen_freq_write(gen_freq_write),
   .gen_enabled_q(gen_enabled_q), .mod_b_bit_q(mod_b_bit_q), .mod_b_active_q(mod_b_active_q),
   .audio_b_bit_q(audio_b_bit_q), .audio_b_active_q(audio_b_active_q), .sync_flag_q(sync_flag_q),
   .result_q(result_q));
`default_nettype wire
